/* rtl/dsp_diu_pkg.sv */
package dsp_diu_pkg;

   // Accumulator width of the core
   localparam int unsigned ACC_W = 32;

   // Instruction selected by the decoder
   typedef enum logic [1:0]
   {
      OP_DIV,
      OP_INC,
      OP_INIT,
      OP_NONE
   } op_e;

   // Accumulator chosen by the increment instruction
   typedef enum logic [1:0]
   {
      SEL_A,
      SEL_B,
      SEL_R,
      SEL_NONE
   } acc_sel_e;

   // Control states
   typedef enum logic
   {
      ST_IDLE,
      ST_RELOAD
   } st_e;

   // The three accumulators
   typedef struct packed
   {
      logic [ACC_W-1:0] a;
      logic [ACC_W-1:0] b;
      logic [ACC_W-1:0] r;
   } acc_s;

   // Condition flags
   typedef struct packed
   {
      logic carry;
      logic overflow;
      logic sign;
      logic zero;
   } flags_s;

   // Whole block state
   typedef struct packed
   {
      st_e        st;
      acc_s       acc;
      logic [2:0] acc_we;
      flags_s     flags;
      logic [3:0] flag_we;
      logic       done;
   } state_s;

   // Write enable masks, bit order {a, b, r}
   localparam logic [2:0] WE_A    = 3'h4;
   localparam logic [2:0] WE_B    = 3'h2;
   localparam logic [2:0] WE_R    = 3'h1;
   localparam logic [2:0] WE_DIV  = 3'h6;
   localparam logic [2:0] WE_NONE = 3'h0;

   // Flag write masks, bit order {carry, overflow, sign, zero}
   localparam logic [3:0] FW_SZ   = 4'h3;
   localparam logic [3:0] FW_ALL  = 4'hF;
   localparam logic [3:0] FW_NONE = 4'h0;

   // Flags left by the initialization instruction
   localparam flags_s INIT_FLAGS = 4'h1;

   // Reset value of the whole state
   localparam state_s STATE_RST = '0;

endpackage

/* rtl/dsp_divide_increment_init.sv */
// Function
// - Divide step: b gets quotient, a twice remainder
// - N steps scale quotient by 2^(N-1)
// - Valid only if b zero, 0<a<2r
// - Pre-shifted operands give 2^(1+ea-er-N) quotient
// - Init resets converters, CPU; updates all flags
// - Init reloads configuration from nonvolatile memory
`timescale 1ns/1ps
`default_nettype none
module dsp_divide_increment_init
   import dsp_diu_pkg::*;
(
   input  wire logic   I_SYS_CLK,           // Core clock
   input  wire logic   I_RST_N,             // Core reset, active low
   input  wire logic   I_OP_VALID,          // Decoder issues an instruction
   input  wire op_e    I_OP,                // Instruction code
   input  wire acc_sel_e I_SEL,             // Accumulator for increment
   input  wire acc_s   I_ACC,               // Current accumulators
   input  wire logic   I_CFG_RELOAD_DONE,   // Config copy finished
   output logic        O_READY,             // Block accepts an instruction
   output logic        O_DONE,              // Result valid pulse
   output acc_s        O_ACC,               // Result accumulators
   output logic [2:0]  O_ACC_WE,            // Accumulator write enables
   output flags_s      O_FLAGS,             // Result flags
   output logic [3:0]  O_FLAG_WE,           // Flag write enables
   output logic        O_CAP_CONV_RST,      // Capacitance converter reset
   output logic        O_RESISTANCE_CONVERTER_RST, // Resistance conv. reset
   output logic        O_CPU_RST,           // CPU reset
   output logic        O_CFG_RELOAD_REQ     // Config reload request
);

   state_s state_q;                          // Registered state
   state_s state_d;                          // Next state

   // Next state logic
   always_comb
   begin
      logic             ge;                  // Dividend reaches divisor
      logic [ACC_W-1:0] diff;                // Dividend minus divisor
      logic [ACC_W-1:0] opnd;                // Increment operand
      logic [ACC_W:0]   sum;                 // Increment sum with carry
      ge   = 1'b0;
      diff = '0;
      opnd = '0;
      sum  = '0;
      state_d         = state_q;
      state_d.done    = 1'b0;
      state_d.acc_we  = WE_NONE;
      state_d.flag_we = FW_NONE;
      case (state_q.st)
         ST_IDLE:                            // Waiting for an instruction
         begin
            if (I_OP_VALID)
            begin
               case (I_OP)
                  OP_DIV:                    // One restoring divide step
                  begin
                     ge   = ({1'b0, I_ACC.a} >= {1'b0, I_ACC.r});
                     diff = I_ACC.a - I_ACC.r;
                     // Quotient bit shifted in; repeats give 2^(N-1)
                     state_d.acc.b = {I_ACC.b[ACC_W-2:0], ge};
                     // Remainder doubled each step
                     state_d.acc.a = ge ? {diff[ACC_W-2:0], 1'b0}
                                        : {I_ACC.a[ACC_W-2:0], 1'b0};
                     state_d.acc.r = I_ACC.r;
                     state_d.acc_we = WE_DIV;
                     state_d.flags.carry    = state_q.flags.carry;
                     state_d.flags.overflow = state_q.flags.overflow;
                     state_d.flags.sign = state_d.acc.b[ACC_W-1];
                     state_d.flags.zero = (state_d.acc.b == '0);
                     state_d.flag_we = FW_SZ;
                     state_d.done    = 1'b1;
                  end
                  OP_INC:                    // Increment one accumulator
                  begin
                     case (I_SEL)
                        SEL_A:   opnd = I_ACC.a;
                        SEL_B:   opnd = I_ACC.b;
                        SEL_R:   opnd = I_ACC.r;
                        default: opnd = I_ACC.a;
                     endcase
                     sum = {1'b0, opnd} + {{ACC_W{1'b0}}, 1'b1};
                     state_d.acc = I_ACC;
                     case (I_SEL)
                        SEL_B:
                        begin
                           state_d.acc.b  = sum[ACC_W-1:0];
                           state_d.acc_we = WE_B;
                        end
                        SEL_R:
                        begin
                           state_d.acc.r  = sum[ACC_W-1:0];
                           state_d.acc_we = WE_R;
                        end
                        default:
                        begin
                           state_d.acc.a  = sum[ACC_W-1:0];
                           state_d.acc_we = WE_A;
                        end
                     endcase
                     state_d.flags.carry    = sum[ACC_W];
                     state_d.flags.overflow = ~opnd[ACC_W-1]
                                              & sum[ACC_W-1];
                     state_d.flags.sign     = sum[ACC_W-1];
                     state_d.flags.zero     = (sum[ACC_W-1:0] == '0);
                     state_d.flag_we        = FW_ALL;
                     state_d.done           = 1'b1;
                  end
                  OP_INIT:                   // Start reset and reload
                  begin
                     state_d.st      = ST_RELOAD;
                     state_d.flags   = INIT_FLAGS;
                     state_d.flag_we = FW_ALL;
                  end
                  default:                   // Not handled here
                  begin
                     state_d.done = 1'b0;
                  end
               endcase
            end
         end
         ST_RELOAD:                          // Hold resets until reload
         begin
            if (I_CFG_RELOAD_DONE)
            begin
               state_d.st   = ST_IDLE;
               state_d.done = 1'b1;
            end
         end
         default:                            // Recover to idle
         begin
            state_d.st = ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RST_N)
         state_q <= STATE_RST;
      else
         state_q <= state_d;
   end

   // Outputs from the state register
   assign O_READY          = (state_q.st == ST_IDLE);
   assign O_DONE           = state_q.done;
   assign O_ACC            = state_q.acc;
   assign O_ACC_WE         = state_q.acc_we;
   assign O_FLAGS          = state_q.flags;
   assign O_FLAG_WE        = state_q.flag_we;
   // All three resets share one source so they act together
   assign O_CAP_CONV_RST   = (state_q.st == ST_RELOAD);
   assign O_RESISTANCE_CONVERTER_RST = (state_q.st == ST_RELOAD);
   assign O_CPU_RST        = (state_q.st == ST_RELOAD);
   assign O_CFG_RELOAD_REQ = (state_q.st == ST_RELOAD);

   default clocking cb @(posedge I_SYS_CLK);
   endclocking
   default disable iff (!I_RST_N);

   // Accepted instructions of each kind
   sequence div_taken;
      I_OP_VALID && O_READY && I_OP == OP_DIV;
   endsequence
   sequence inc_taken;
      I_OP_VALID && O_READY && I_OP == OP_INC;
   endsequence
   sequence init_taken;
      I_OP_VALID && O_READY && I_OP == OP_INIT;
   endsequence

   div_step_a: assert property (div_taken |=> O_DONE && O_ACC_WE == WE_DIV
      && O_FLAG_WE == FW_SZ && O_ACC.b[0] == ($past(I_ACC.a)
      >= $past(I_ACC.r)))
      else $error("divide step result wrong");

   div_shift_a: assert property (div_taken |=> O_ACC.b[ACC_W-1:1]
      == $past(I_ACC.b[ACC_W-2:0]))
      else $error("quotient not shifted");

   div_valid_a: assert property (div_taken and (I_ACC.b == '0
      && I_ACC.a != '0 && {1'b0, I_ACC.a} < {I_ACC.r, 1'b0})
      |=> O_ACC.b == (ACC_W'($past(I_ACC.a) / $past(I_ACC.r))))
      else $error("single step quotient wrong");

   div_rem_a: assert property (div_taken and ({1'b0, I_ACC.a}
      < {I_ACC.r, 1'b0}) and (I_ACC.r[ACC_W-1] == 1'b0)
      |=> O_ACC.a < {$past(I_ACC.r[ACC_W-2:0]), 1'b0})
      else $error("remainder out of range");

   init_reset_a: assert property (init_taken |=> O_CAP_CONV_RST
      && O_RESISTANCE_CONVERTER_RST && O_CPU_RST
      && O_FLAG_WE == FW_ALL && O_FLAGS == INIT_FLAGS)
      else $error("init reset missing");

   init_reload_a: assert property (init_taken ##1 !I_CFG_RELOAD_DONE
      |=> O_CFG_RELOAD_REQ && !O_READY)
      else $error("reload request dropped");

   reload_end_a: assert property (O_CFG_RELOAD_REQ && I_CFG_RELOAD_DONE
      |=> O_DONE && O_READY && !O_CPU_RST)
      else $error("reload did not finish");

   inc_sum_a: assert property (inc_taken and (I_SEL == SEL_B)
      |=> O_ACC.b == $past(I_ACC.b) + 1'b1 && O_ACC_WE == WE_B
      && O_FLAGS.zero == (O_ACC.b == '0)
      && O_FLAGS.carry == ($past(I_ACC.b) == '1))
      else $error("increment result wrong");

   // Divide leaves carry and overflow untouched
   div_flags_a: assert property (div_taken |=> O_FLAGS.carry
      == $past(O_FLAGS.carry)
      && O_FLAGS.overflow == $past(O_FLAGS.overflow))
      else $error("divide changed carry or overflow");

   // Increment writes exactly one accumulator and all flags
   inc_flags_a: assert property (inc_taken |=> O_DONE
      && O_FLAG_WE == FW_ALL && $onehot(O_ACC_WE))
      else $error("increment enables wrong");

   // Nothing is executed while the reload is pending
   reload_refuse_a: assert property (O_CFG_RELOAD_REQ
      && !I_CFG_RELOAD_DONE |=> !O_DONE && O_ACC_WE == WE_NONE
      && O_CFG_RELOAD_REQ)
      else $error("instruction taken during reload");

endmodule
`default_nettype wire

/* tb/dsp_divide_increment_init_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dsp_divide_increment_init_test
   import dsp_diu_pkg::*;
();
   logic       clk = 1'b0;    // Core clock
   logic       rst_n = 1'b0;  // Core reset, active low
   logic       vld = 1'b0;    // Instruction strobe
   logic       rld = 1'b0;    // Reload finished
   op_e        op = OP_NONE;  // Instruction code
   acc_sel_e   sel = SEL_A;   // Increment target
   acc_s       acc = '0;      // Accumulators in
   logic       rdy, done;     // Handshake out
   acc_s       oacc;          // Accumulators out
   logic [2:0] awe;           // Accumulator write enables
   flags_s     ofl;           // Flags out
   logic [3:0] fwe;           // Flag write enables
   logic       crst, rrst, cpurst, req; // Init side outputs
   int         error_cnt = 0; // Mismatches
   int         n_tests = 0;   // Comparisons
   acc_s       v, e;          // Operands and expected result
   logic [63:0] q, a0, r0;    // Wide divide reference
   logic [32:0] s;            // Increment sum with carry
   logic [31:0] x;            // Increment operand
   int         n;             // Divide step count

   // Clock at 100 MHz
   always #5 clk = ~clk;

   dsp_divide_increment_init dut (.I_SYS_CLK(clk), .I_RST_N(rst_n),
      .I_OP_VALID(vld), .I_OP(op), .I_SEL(sel), .I_ACC(acc),
      .I_CFG_RELOAD_DONE(rld), .O_READY(rdy), .O_DONE(done),
      .O_ACC(oacc), .O_ACC_WE(awe), .O_FLAGS(ofl), .O_FLAG_WE(fwe),
      .O_CAP_CONV_RST(crst), .O_RESISTANCE_CONVERTER_RST(rrst),
      .O_CPU_RST(cpurst), .O_CFG_RELOAD_REQ(req));

   // Compare and report
   task chk(input logic [95:0] seen, input logic [95:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   // Print the verdict and stop
   task give_verdict;
      if (error_cnt == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Issue one instruction; return at the negedge after its result
   task go(input op_e o, input acc_sel_e s, input acc_s a);
      @(negedge clk);
      op = o;
      sel = s;
      acc = a;
      vld = 1'b1;
      @(negedge clk);
      vld = 1'b0;
   endtask

   // Restoring divide step reference
   function acc_s div_ref(input acc_s a);
      logic ge;
      ge = a.a >= a.r;
      div_ref.r = a.r;
      div_ref.b = {a.b[ACC_W-2:0], ge};
      div_ref.a = (ge ? a.a - a.r : a.a) << 1;
   endfunction

   // Watchdog, far beyond the expected run length
   initial
   begin
      #200000;
      error_cnt++;
      give_verdict();
   end

   // Main sequence
   initial
   begin
      void'($urandom(1));
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      chk({rdy, done, awe, fwe, req}, {1'b1, 9'h0});
      // An unused code must leave no trace
      go(OP_NONE, SEL_A, '{32'h5, 32'h0, 32'h3});
      chk({rdy, done, awe, fwe, req}, {1'b1, 9'h0});
      // Divide chains: random, then largest a and smallest a
      for (int t = 0; t < 12; t++)
      begin
         r0 = ({32'h0, $urandom} >> 1) | 64'h1;
         a0 = 64'h1 + {32'h0, $urandom} % (2 * r0 - 1);
         n = 1 + $urandom % 32;
         // Largest legal dividend, full length chain
         if (t == 10)
         begin
            a0 = 2 * r0 - 1;
            n  = 32;
         end
         // Smallest dividend against a large divisor
         if (t == 11)
         begin
            a0 = 64'h1;
            r0 = 64'h7FFFFFFF;
         end
         v = '{a0[31:0], 32'h0, r0[31:0]};
         for (int k = 0; k < n; k++)
         begin
            go(OP_DIV, SEL_A, v);
            e = div_ref(v);
            chk(oacc, e);
            chk({done, awe, fwe}, {1'b1, WE_DIV, FW_SZ});
            chk({ofl.sign, ofl.zero}, {e.b[31], e.b == 0});
            v = e;
         end
         q = (a0 << (n - 1)) / r0;
         chk(v.b, q[31:0]);
         chk(v.a, 2 * ((a0 << (n - 1)) - q * r0));
      end
      // Increment on every target with boundary values
      for (int t = 0; t < 16; t++)
      begin
         x = (t % 4 == 0) ? 32'hFFFFFFFF : (t % 4 == 1) ? 32'h7FFFFFFF :
             (t % 4 == 2) ? 32'h0 : $urandom;
         s = {1'b0, x} + 33'h1;
         go(OP_INC, acc_sel_e'(t / 4), '{x, x, x});
         case (acc_sel_e'(t / 4))
            SEL_B:   chk({oacc.b, awe}, {s[31:0], WE_B});
            SEL_R:   chk({oacc.r, awe}, {s[31:0], WE_R});
            default: chk({oacc.a, awe}, {s[31:0], WE_A});
         endcase
         chk({done, fwe, ofl}, {1'b1, FW_ALL, s[32], x == 32'h7FFFFFFF,
             s[31], s[31:0] == 32'h0});
      end
      // Initialization, with a refused divide while reloading
      for (int t = 0; t < 4; t++)
      begin
         go(OP_INIT, SEL_A, '0);
         chk({rdy, crst, rrst, cpurst, fwe, ofl},
             {1'b0, 3'h7, FW_ALL, INIT_FLAGS});
         chk(req, 1'b1);
         go(OP_DIV, SEL_A, '{32'h5, 32'h0, 32'h3});
         chk({done, awe, crst, req}, 6'h3);
         repeat ($urandom % 5) @(negedge clk);
         rld = 1'b1;
         @(negedge clk);
         rld = 1'b0;
         chk({done, rdy, crst, rrst, cpurst, req}, 6'h30);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
